// File: hbi_map.svh
// Constant map of the UART host bus interface
`ifndef HBI_MAP_SVH
`define HBI_MAP_SVH

// ****************************************
// Widths
// ****************************************
`define HBI_SEL_W     3
`define HBI_DATA_W    8
`define HBI_PINS_W    19

// ****************************************
// Reset values
// ****************************************
// Idle pin image: selects off, low-active strobes high, data zero
`define HBI_PINS_IDLE 19'h02a00
`define HBI_SEL_RST   3'h0
`define HBI_DATA_RST  8'h00

`endif

// File: hbi_pkg.sv
// Types shared by the UART host bus interface
`default_nettype none

package hbi_pkg;

  // ****************************************
  // Host pin image, one sample per clock
  // ****************************************
  typedef struct packed {
    logic [2:0] reg_select;
    logic       chip_select_a;
    logic       chip_select_b;
    logic       chip_select_n;
    logic       read_strobe_hi;
    logic       read_strobe_lo;
    logic       write_strobe_hi;
    logic       write_strobe_lo;
    logic       addr_latch_strobe;
    logic [7:0] host_data_in;
  } hbi_pins_t;

  // ****************************************
  // Captured address phase
  // ****************************************
  typedef struct packed {
    logic [2:0] reg_select;
    logic       chip_select_a;
    logic       chip_select_b;
    logic       chip_select_n;
  } hbi_addr_t;

endpackage : hbi_pkg

`default_nettype wire

// File: hbi_sync.sv
// Two-stage synchroniser for a vector of host pins
`default_nettype none

module hbi_sync #(
  parameter int                   W       = 1,
  parameter logic [W-1:0]         RST_VAL = '0
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic [W-1:0]       async_in,
  output var  logic [W-1:0]       sync_out
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // hbi_sync

`default_nettype wire

// File: hbi_host_port.sv
// Parallel host bus port of the UART: select decode, address latch, strobes, data bus
//
// Functional notes
// - Register select picks the addressed register
// - Selected only when A high, B high, N low
// - Either read strobe drives register onto bus
// - Either write strobe stores bus into register
// - Latch strobe rising edge captures selects
// - Eight-bit bus driven only during selected read
// - Bus bit zero is least significant
// - Low read_strobe_lo equals high read_strobe_hi
// - Low write_strobe_lo writes addressed register
// - drive_disable_n low only while host reads
`include "hbi_map.svh"
`default_nettype none

module hbi_host_port (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Host pins
  input  wire logic [`HBI_SEL_W-1:0]     reg_select,
  input  wire logic                      chip_select_a,
  input  wire logic                      chip_select_b,
  input  wire logic                      chip_select_n,
  input  wire logic                      read_strobe_hi,
  input  wire logic                      read_strobe_lo,
  input  wire logic                      write_strobe_hi,
  input  wire logic                      write_strobe_lo,
  input  wire logic                      addr_latch_strobe,
  input  wire logic [`HBI_DATA_W-1:0]    host_data_in,
  output var  logic [`HBI_DATA_W-1:0]    host_data_out,
  output var  logic                      host_data_oe,
  output var  logic                      drive_disable_n,
  // Core register side
  output var  logic [`HBI_SEL_W-1:0]     core_reg_idx,
  output var  logic                      core_rd_pulse,
  output var  logic                      core_rd_active,
  input  wire logic [`HBI_DATA_W-1:0]    core_rd_data,
  output var  logic                      core_wr_pulse,
  output var  logic [`HBI_DATA_W-1:0]    core_wr_data
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  hbi_pkg::hbi_pins_t pins_raw;
  hbi_pkg::hbi_pins_t pins_s;

  assign pins_raw = '{
    reg_select:        reg_select,
    chip_select_a:     chip_select_a,
    chip_select_b:     chip_select_b,
    chip_select_n:     chip_select_n,
    read_strobe_hi:    read_strobe_hi,
    read_strobe_lo:    read_strobe_lo,
    write_strobe_hi:   write_strobe_hi,
    write_strobe_lo:   write_strobe_lo,
    addr_latch_strobe: addr_latch_strobe,
    host_data_in:      host_data_in
  };

  hbi_sync #(
    .W       (`HBI_PINS_W),
    .RST_VAL (`HBI_PINS_IDLE)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  // ****************************************
  // Address latch
  // ****************************************
  hbi_pkg::hbi_addr_t addr_live;
  hbi_pkg::hbi_addr_t addr_hold_r;
  hbi_pkg::hbi_addr_t addr_eff;
  logic               als_prev_r;
  wire                als_rise;
  wire                hold_use;

  assign addr_live = '{
    reg_select:    pins_s.reg_select,
    chip_select_a: pins_s.chip_select_a,
    chip_select_b: pins_s.chip_select_b,
    chip_select_n: pins_s.chip_select_n
  };
  assign als_rise  = pins_s.addr_latch_strobe & ~als_prev_r;
  // Transparent while strobe low, frozen image while high
  // Rising cycle passes the image being captured, so no stale select leaks out
  assign hold_use  = pins_s.addr_latch_strobe & ~als_rise;
  assign addr_eff  = hold_use ? addr_hold_r : addr_live;

  // Edge detector idles low like the pin, so reset gives no false edge
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      als_prev_r <= 1'b0;
    else
      als_prev_r <= pins_s.addr_latch_strobe;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      addr_hold_r <= '{`HBI_SEL_RST, 1'b0, 1'b0, 1'b1};
    else if (als_rise)
      addr_hold_r <= addr_live;
  end

  // ****************************************
  // Strobe pair decode
  // ****************************************
  // Either pin of a pair requests; the unused pin idles inactive
  function automatic logic strobe_on(input logic hi_pin, input logic lo_pin);
    strobe_on = hi_pin | ~lo_pin;
  endfunction

  // ****************************************
  // Select and strobe decode
  // ****************************************
  wire chip_sel;
  wire rd_req;
  wire wr_req;

  // Unused selects are expected tied asserted by the board
  assign chip_sel = addr_eff.chip_select_a & addr_eff.chip_select_b & ~addr_eff.chip_select_n;
  // The unused strobe of each pair must idle inactive, else it masks the other
  assign rd_req   = chip_sel & strobe_on(pins_s.read_strobe_hi, pins_s.read_strobe_lo);
  assign wr_req   = chip_sel & strobe_on(pins_s.write_strobe_hi, pins_s.write_strobe_lo);

  // ****************************************
  // Access sequencing
  // ****************************************
  logic                   rd_req_r;
  logic                   wr_req_r;
  logic [`HBI_DATA_W-1:0] wr_data_r;
  logic [`HBI_SEL_W-1:0]  wr_idx_r;

  // Strobe history for edge detection
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
    end
    else
    begin
      rd_req_r <= rd_req;
      wr_req_r <= wr_req;
    end
  end

  // Write commits at the strobe's trailing edge, when host data has settled;
  // the last sample taken while the strobe is active is the one kept
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_data_r <= `HBI_DATA_RST;
      wr_idx_r  <= `HBI_SEL_RST;
    end
    else if (wr_req)
    begin
      wr_data_r <= pins_s.host_data_in;
      wr_idx_r  <= addr_eff.reg_select;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  wire wr_done;
  wire [`HBI_SEL_W-1:0] idx_nxt;

  assign wr_done = wr_req_r & ~wr_req;
  assign idx_nxt = wr_done ? wr_idx_r : addr_eff.reg_select;

  // Read side: bus drive, transceiver steering, read strobes to the core
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      core_rd_pulse   <= 1'b0;
      core_rd_active  <= 1'b0;
      host_data_out   <= `HBI_DATA_RST;
      host_data_oe    <= 1'b0;
      drive_disable_n <= 1'b1;
    end
    else
    begin
      core_rd_pulse   <= rd_req & ~rd_req_r;
      core_rd_active  <= rd_req;
      host_data_out   <= rd_req ? core_rd_data : `HBI_DATA_RST;
      host_data_oe    <= rd_req;
      drive_disable_n <= ~rd_req;
    end
  end

  // Write side and register index
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      core_reg_idx  <= `HBI_SEL_RST;
      core_wr_pulse <= 1'b0;
      core_wr_data  <= `HBI_DATA_RST;
    end
    else
    begin
      core_reg_idx  <= idx_nxt;
      core_wr_pulse <= wr_done;
      core_wr_data  <= wr_data_r;
    end
  end

endmodule // hbi_host_port

`default_nettype wire

// File: hbi_chk_sva.sv
// Assertion checker for the UART host bus port
`default_nettype none
module hbi_chk (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [2:0] reg_select,
  input wire logic       chip_select_a,
  input wire logic       chip_select_b,
  input wire logic       chip_select_n,
  input wire logic       read_strobe_hi,
  input wire logic       read_strobe_lo,
  input wire logic       addr_latch_strobe,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe,
  input wire logic       drive_disable_n,
  input wire logic [2:0] core_reg_idx,
  input wire logic       core_rd_pulse,
  input wire logic       core_wr_pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Live pins only; a high latch strobe means held selects
  wire logic sel = chip_select_a && chip_select_b && !chip_select_n && !addr_latch_strobe;
  wire logic rd = sel && (read_strobe_hi || !read_strobe_lo);
  sequence rd_held; rd[*4]; endsequence
  sequence idle_held; (!rd && !addr_latch_strobe)[*4]; endsequence
  rd_on_a: assert property (rd_held |-> host_data_oe && !drive_disable_n) else $error("no drive");
  desel_a: assert property (idle_held |-> !host_data_oe && drive_disable_n) else $error("bus driven");
  oe_drive_disable_n_a: assert property (host_data_oe != drive_disable_n) else $error("drive_disable_n wrong");
  idle_bus_a: assert property (!host_data_oe |-> host_data_out == 8'h00) else $error("data set");
  rd_pulse_a: assert property (core_rd_pulse |-> host_data_oe ##1 !core_rd_pulse)
    else $error("rd pulse");
  wr_pulse_a: assert property (core_wr_pulse |=> !core_wr_pulse) else $error("wr pulse");
  idx_sel_a: assert property ((rd && $stable(reg_select))[*5] |-> core_reg_idx == reg_select)
    else $error("idx");
  sel_hold_a: assert property (addr_latch_strobe[*6] |-> $stable(core_reg_idx))
    else $error("idx moved");
endmodule // hbi_chk
`default_nettype wire

// File: hbi_host.sv
// Host processor model for the UART bus pins
`default_nettype none
module hbi_host (
  input wire logic               sys_clk,
  output var hbi_pkg::hbi_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strobe code {read hi, read lo, write hi, write lo}; unused high strobes kept low
  initial pins = {3'h0, 3'h1, 4'h5, 1'h0, 8'h00};
  task automatic acc(input logic [2:0] idx, cs, input logic [3:0] str, input logic als, input logic [7:0] d);
    @(posedge sys_clk) #1;
    pins = {idx, cs, str, als, d};
  endtask
  task automatic stop();
    @(posedge sys_clk) #1;
    pins[12:9] = 4'h5;
    @(posedge sys_clk) #1;
    // Released bus floats; inverse avoids a stale value passing
    pins[15:13] = 3'h1;
    pins.host_data_in = ~pins.host_data_in;
  endtask
endmodule // hbi_host
`default_nettype wire

// File: hbi_host_port_tb.sv
// Self-checking bench for the UART host bus port
`default_nettype none
module hbi_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  hbi_pkg::hbi_pins_t pins;
  logic [2:0]         reg_select, core_reg_idx;
  logic [7:0]         host_d, host_data_in, host_data_out, core_wr_data, core_rd_data;
  logic               chip_select_a, chip_select_b, chip_select_n, read_strobe_hi, read_strobe_lo;
  logic               write_strobe_hi, write_strobe_lo, addr_latch_strobe, host_data_oe, drive_disable_n;
  logic               core_rd_pulse, core_rd_active, core_wr_pulse;
  int                 num_errors = 0;
  int                 compares = 0;
  assign {reg_select, chip_select_a, chip_select_b, chip_select_n, read_strobe_hi, read_strobe_lo,
    write_strobe_hi, write_strobe_lo, addr_latch_strobe, host_d} = pins;
  assign host_data_in = host_data_oe ? host_data_out : host_d;
  // Core image differs per index so a wrong select shows
  assign core_rd_data = 8'ha0 ^ {5'h00, core_reg_idx};
  initial forever #50 sys_clk = ~sys_clk;
  hbi_host host (.sys_clk(sys_clk), .pins(pins));
  hbi_host_port dut (
    .sys_clk           (sys_clk),
    .rst               (rst),
    .reg_select        (reg_select),
    .chip_select_a     (chip_select_a),
    .chip_select_b     (chip_select_b),
    .chip_select_n     (chip_select_n),
    .read_strobe_hi    (read_strobe_hi),
    .read_strobe_lo    (read_strobe_lo),
    .write_strobe_hi   (write_strobe_hi),
    .write_strobe_lo   (write_strobe_lo),
    .addr_latch_strobe (addr_latch_strobe),
    .host_data_in      (host_data_in),
    .host_data_out     (host_data_out),
    .host_data_oe      (host_data_oe),
    .drive_disable_n   (drive_disable_n),
    .core_reg_idx      (core_reg_idx),
    .core_rd_pulse     (core_rd_pulse),
    .core_rd_active    (core_rd_active),
    .core_rd_data      (core_rd_data),
    .core_wr_pulse     (core_wr_pulse),
    .core_wr_data      (core_wr_data)
  );
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait5();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic test_read();
    for (int k = 0; k < 2; k++)
    begin
      host.acc(k ? 3'h7 : 3'h0, 3'h6, k ? 4'hd : 4'h1, 1'b0, 8'h00);
      repeat (3) @(posedge sys_clk);
      #1;
      check({7'h00, core_rd_pulse}, 8'h01);
      repeat (2) @(posedge sys_clk);
      #1;
      check({4'h0, core_rd_pulse, host_data_oe, drive_disable_n, core_rd_active}, 8'h05);
      check(host_data_in, k ? 8'ha7 : 8'ha0);
      host.stop();
      wait5();
      check({5'h00, host_data_oe, drive_disable_n, core_rd_active}, 8'h02);
    end
    $display("test_read done");
  endtask
  task automatic test_write();
    for (int k = 0; k < 2; k++)
    begin
      host.acc(k ? 3'h7 : 3'h3, 3'h6, k ? 4'h7 : 4'h4, 1'b0, k ? 8'h80 : 8'h01);
      repeat (3) @(posedge sys_clk);
      host.stop();
      for (int n = 0; n < 8 && core_wr_pulse !== 1'b1; n++)
        @(posedge sys_clk) #1;
      check({4'h0, core_wr_pulse, core_reg_idx}, k ? 8'h0f : 8'h0b);
      check(core_wr_data, k ? 8'h80 : 8'h01);
    end
    $display("test_write done");
  endtask
  task automatic test_desel();
    for (int i = 0; i < 3; i++)
    begin
      host.acc(3'h5, 3'b110 ^ (3'b100 >> i), 4'h1, 1'b0, 8'h00);
      wait5();
      check({6'h00, host_data_oe, drive_disable_n}, 8'h01);
      host.stop();
    end
    $display("test_desel done");
  endtask
  task automatic test_latch();
    host.acc(3'h6, 3'h6, 4'h5, 1'b0, 8'h00);
    host.acc(3'h6, 3'h6, 4'h5, 1'b1, 8'h00);
    host.acc(3'h1, 3'h1, 4'hd, 1'b1, 8'h00);
    wait5();
    check({4'h0, host_data_oe, core_reg_idx}, 8'h0e);
    check(host_data_in, 8'ha6);
    host.stop();
    host.acc(3'h1, 3'h1, 4'h5, 1'b0, 8'h00);
    wait5();
    check({7'h00, host_data_oe}, 8'h00);
    $display("test_latch done");
  endtask
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    test_read();
    test_write();
    test_desel();
    test_latch();
    wrap_up();
  end
endmodule // hbi_host_port_tb
bind hbi_host_port hbi_chk chk (
  .sys_clk           (sys_clk),
  .rst               (rst),
  .reg_select        (reg_select),
  .chip_select_a     (chip_select_a),
  .chip_select_b     (chip_select_b),
  .chip_select_n     (chip_select_n),
  .read_strobe_hi    (read_strobe_hi),
  .read_strobe_lo    (read_strobe_lo),
  .addr_latch_strobe (addr_latch_strobe),
  .host_data_out     (host_data_out),
  .host_data_oe      (host_data_oe),
  .drive_disable_n   (drive_disable_n),
  .core_reg_idx      (core_reg_idx),
  .core_rd_pulse     (core_rd_pulse),
  .core_wr_pulse     (core_wr_pulse)
);
`default_nettype wire
